// *** core/cpa_pkg.sv ***
// constants shared by both ends of the configuration port
// Operation
// - enable low idles; high starts one access
// - write select picks read or write
// - write strobes high one cycle only
// - device raises ready on completion
// - host supplies 16-bit write data
// - device returns 16-bit read data
// - unused port: clock low, no accesses
package cpa_pkg;
    localparam int CPA_ADDR_W = 10;
    localparam int CPA_DATA_W = 16;
    localparam int CPA_DEPTH = 1024;
    localparam logic [CPA_DATA_W-1:0] CPA_MEM_RST = 16'h0000;
    // busy cycles between an accepted strobe and the finishing cycle, at least one
    localparam logic [1:0] CPA_ACC_LAT = 2'h2;
    typedef enum logic [2:0] {
        CPA_IDLE = 3'b001,
        CPA_BUSY = 3'b010,
        CPA_DONE = 3'b100
    } cpa_state_e;
endpackage

// *** core/cpa_if.sv ***
// link between configuration port owner and its user logic
`timescale 1ns/1ns
interface cpa_if;
    import cpa_pkg::*;
    logic en;
    logic we;
    logic [CPA_ADDR_W-1:0] addr;
    logic [CPA_DATA_W-1:0] cfg_port_write_data;
    logic [CPA_DATA_W-1:0] rdata;
    logic rdy;
    modport dev (input en, input we, input addr, input cfg_port_write_data,
                 output rdata, output rdy);
    modport usr (output en, output we, output addr, output cfg_port_write_data,
                 input rdata, input rdy);
endinterface

// *** core/cpa_dev.sv ***
// device end: configuration store answering single-word accesses
`timescale 1ns/1ns
module cpa_dev
    import cpa_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    cpa_if.dev port,
    output logic [CPA_DATA_W-1:0] busy_cnt_o
);
    // configuration store, one word per address
    logic [CPA_DATA_W-1:0] mem_q [CPA_DEPTH];
    logic [CPA_DATA_W-1:0] mem_d [CPA_DEPTH];

    // access engine state and its wait counter
    cpa_state_e st_q;
    cpa_state_e st_d;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;

    // request fields captured when the strobe is taken
    logic we_q;
    logic we_d;
    logic [CPA_ADDR_W-1:0] adr_q;
    logic [CPA_ADDR_W-1:0] adr_d;
    logic [CPA_DATA_W-1:0] wd_q;
    logic [CPA_DATA_W-1:0] wd_d;

    // answer towards the user end
    logic [CPA_DATA_W-1:0] rd_q;
    logic [CPA_DATA_W-1:0] rd_d;
    logic rdy_q;
    logic rdy_d;

    // status count of busy cycles
    logic [CPA_DATA_W-1:0] bc_q;
    logic [CPA_DATA_W-1:0] bc_d;

    // events decoded from the engine state
    logic take_acc; // strobe accepted this cycle
    logic wr_fire; // finishing cycle of a write
    logic rd_fire; // finishing cycle of a read

    // one access, counted in edges from the edge that takes the strobe:
    //   edge 0: request fields loaded, engine goes busy
    //   edges 1 and 2: busy, one edge per latency count
    //   edge 3: store written or word read, ready raised
    //   ready stands one cycle; a strobe seen before the engine is idle is dropped

    // a strobe counts only while the engine is idle
    function automatic logic acc_taken(input cpa_state_e st, input logic en);
        acc_taken = (st == CPA_IDLE) && en;
    endfunction

    // finishing cycle of an access in the given direction
    function automatic logic acc_finish(input cpa_state_e st, input logic we,
                                        input logic dir);
        acc_finish = (st == CPA_DONE) && (we == dir);
    endfunction

    // decode of the events that drive the other groups
    always_comb begin
        take_acc = acc_taken(st_q, port.en);
        wr_fire = acc_finish(st_q, we_q, 1'b1);
        rd_fire = acc_finish(st_q, we_q, 1'b0);
    end

    // next state of the access engine
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            CPA_IDLE: begin
                if (take_acc) begin
                    cnt_d = CPA_ACC_LAT - 2'h1;
                    st_d = CPA_BUSY;
                end
            end
            CPA_BUSY: begin
                if (cnt_q == 2'h0) begin
                    st_d = CPA_DONE;
                end else begin
                    cnt_d = cnt_q - 2'h1;
                end
            end
            CPA_DONE: begin
                st_d = CPA_IDLE;
            end
            default: begin
                st_d = CPA_IDLE;
                cnt_d = 2'h0;
            end
        endcase
    end

    // registers of the access engine
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_q <= CPA_IDLE;
            cnt_q <= 2'h0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // request fields, loaded only when a strobe is taken and kept until the next
    always_comb begin
        we_d = we_q;
        adr_d = adr_q;
        wd_d = wd_q;
        if (take_acc) begin
            we_d = port.we;
            adr_d = port.addr;
            wd_d = port.cfg_port_write_data;
        end
    end

    // registers of the captured request
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            we_q <= 1'b0;
            adr_q <= '0;
            wd_q <= '0;
        end else begin
            we_q <= we_d;
            adr_q <= adr_d;
            wd_q <= wd_d;
        end
    end

    // read data: loaded from the store in the finishing cycle of a read
    always_comb begin
        rd_d = rd_q;
        if (rd_fire) begin
            rd_d = mem_q[adr_q];
        end
    end

    // register of the read data, which holds until the next read
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rd_q <= '0;
        end else begin
            rd_q <= rd_d;
        end
    end

    // ready: one pulse per completed access
    always_comb begin
        rdy_d = wr_fire || rd_fire;
    end

    // register of the ready pulse
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= rdy_d;
        end
    end

    // busy cycle count; wraps silently after the top value
    always_comb begin
        bc_d = bc_q;
        if (st_q == CPA_BUSY) begin
            bc_d = bc_q + 16'h0001;
        end
    end

    // register of the busy cycle count
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            bc_q <= '0;
        end else begin
            bc_q <= bc_d;
        end
    end

    // store words: a word changes only when the finishing write hits it
    // one access at a time, so a word is never read and written in one cycle
    for (genvar g = 0; g < CPA_DEPTH; g++) begin : g_word
        // next value of one word
        always_comb begin
            mem_d[g] = mem_q[g];
            if (wr_fire && (adr_q == CPA_ADDR_W'(g))) begin
                mem_d[g] = wd_q;
            end
        end

        // register of one word, cleared by reset
        always_ff @(posedge clk_i) begin
            if (!rst_b_i) begin
                mem_q[g] <= CPA_MEM_RST;
            end else begin
                mem_q[g] <= mem_d[g];
            end
        end
    end

    // outputs come straight from their registers
    assign port.rdata = rd_q;
    assign port.rdy = rdy_q;
    assign busy_cnt_o = bc_q; // total busy cycles seen
endmodule

// *** core/cpa_usr.sv ***
// user end: issues one access per request and waits for ready
`timescale 1ns/1ns
module cpa_usr
    import cpa_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic req_i,
    input wire logic req_we_i,
    input wire logic [CPA_ADDR_W-1:0] req_addr_i,
    input wire logic [CPA_DATA_W-1:0] req_wdata_i,
    output logic busy_o,
    output logic done_o,
    output logic [CPA_DATA_W-1:0] rdata_o,
    cpa_if.usr port
);
    cpa_state_e st_q, st_d;
    logic en_q, en_d;
    logic we_q, we_d;
    logic [CPA_ADDR_W-1:0] adr_q, adr_d;
    logic [CPA_DATA_W-1:0] wd_q, wd_d;
    logic [CPA_DATA_W-1:0] rd_q, rd_d;
    logic done_q, done_d;
    logic busy_q, busy_d;

    // request sequencing
    always_comb begin
        st_d = st_q;
        en_d = 1'b0;
        we_d = 1'b0;
        adr_d = adr_q;
        wd_d = wd_q;
        rd_d = rd_q;
        done_d = 1'b0;
        case (st_q)
            CPA_IDLE: begin
                if (req_i) begin
                    en_d = 1'b1;
                    we_d = req_we_i;
                    adr_d = req_addr_i;
                    wd_d = req_wdata_i;
                    st_d = CPA_BUSY;
                end
            end
            CPA_BUSY: begin
                if (port.rdy && !en_q) begin
                    rd_d = port.rdata;
                    done_d = 1'b1;
                    st_d = CPA_IDLE;
                end
            end
            default: st_d = CPA_IDLE;
        endcase
        // busy flag registered so the output comes from a flip-flop
        busy_d = (st_d == CPA_BUSY);
    end

    // registers of the request side
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_q <= CPA_IDLE;
            en_q <= 1'b0;
            we_q <= 1'b0;
            adr_q <= '0;
            wd_q <= '0;
            rd_q <= '0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            en_q <= en_d;
            we_q <= we_d;
            adr_q <= adr_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
            done_q <= done_d;
            busy_q <= busy_d;
        end
    end

    assign port.en = en_q;
    assign port.we = we_q;
    assign port.addr = adr_q;
    assign port.cfg_port_write_data = wd_q;
    assign busy_o = busy_q;
    assign done_o = done_q;
    assign rdata_o = rd_q;
endmodule

// *** testbench/cpa_chk_sva.sv ***
// checker for the configuration port handshake
`timescale 1ns/1ns
module cpa_chk
    import cpa_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic en,
    input wire logic we,
    input wire logic [CPA_ADDR_W-1:0] addr,
    input wire logic [CPA_DATA_W-1:0] cfg_port_write_data,
    input wire logic [CPA_DATA_W-1:0] rdata,
    input wire logic rdy
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // two busy cycles and the finishing cycle, then the answer
    sequence s_wait;
        !rdy ##1 !rdy ##1 !rdy ##1 rdy;
    endsequence
    // handshake timing and held values
    chk_rdy_after_en: assert property (en |=> s_wait) else $error("late ready");
    chk_wr_one_cyc: assert property (en && we |=> !(en && we)) else $error("long write");
    chk_no_en_busy: assert property (en |=> (!en)[*4]) else $error("early access");
    chk_rdy_cause: assert property (rdy |-> $past(en, 4)) else $error("stray ready");
    chk_rdy_pulse: assert property (rdy |=> !rdy) else $error("long ready");
    chk_addr_held: assert property (en |=> $stable(addr)[*4]) else $error("addr moved");
    chk_wdata_held: assert property (en && we |=> $stable(cfg_port_write_data)[*4])
        else $error("data moved");
    chk_rdata_kept: assert property (!(rdy && !$past(we, 4)) |-> $stable(rdata))
        else $error("rdata moved");
endmodule

// *** testbench/tb.sv ***
// bench joining the user end to the device end
`timescale 1ns/1ns
module tb;
    import cpa_pkg::*;
    logic clk_i = 0;
    logic rst_b_i = 0;
    logic req_i = 0;
    logic req_we_i = 0;
    logic [CPA_ADDR_W-1:0] req_addr_i = '0;
    logic [CPA_DATA_W-1:0] req_wdata_i = '0;
    logic busy_o;
    logic done_o;
    logic [CPA_DATA_W-1:0] rdata_o;
    logic [CPA_DATA_W-1:0] busy_cnt_o;
    int error_cnt = 0;
    int checks = 0;
    cpa_if port ();
    cpa_dev cpa_dev_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .port(port), .busy_cnt_o(busy_cnt_o));
    cpa_usr cpa_usr_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .req_we_i(req_we_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .busy_o(busy_o), .done_o(done_o),
        .rdata_o(rdata_o), .port(port));
    cpa_chk cpa_chk_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .en(port.en), .we(port.we),
        .addr(port.addr), .cfg_port_write_data(port.cfg_port_write_data),
        .rdata(port.rdata), .rdy(port.rdy));
    // compare and count
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // verdict
    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one access through the user end, read data compared to exp
    task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] d,
                       input logic [15:0] e);
        int n;
        @(negedge clk_i);
        req_i = 1;
        req_we_i = w;
        req_addr_i = a;
        req_wdata_i = d;
        @(negedge clk_i);
        req_i = 0;
        n = 1;
        chk("busy_o", {15'h0000, busy_o}, 16'h0001);
        while (done_o !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 20) begin
            error_cnt++;
            end_of_test();
        end
        chk("latency", 16'(n), 16'h0006);
        chk("busy_o", {15'h0000, busy_o}, 16'h0000);
        chk("addr", {6'h00, port.addr}, {6'h00, a});
        if (w)
            chk("wdata", port.cfg_port_write_data, d);
        else
            chk("rdata", rdata_o, e);
    endtask
    // free running clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // reset, then writes and reads at the address boundaries
    initial begin
        repeat (8) @(negedge clk_i);
        rst_b_i = 1;
        chk("idle", {15'h0000, port.en}, 16'h0000);
        acc(0, 10'h3ff, 16'h0000, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            acc(1, 10'(i * 341), 16'ha5c3 ^ 16'(i), 16'h0000);
        end
        for (int i = 0; i < 4; i++) begin
            acc(0, 10'(i * 341), 16'h0000, 16'ha5c3 ^ 16'(i));
        end
        acc(1, 10'h3ff, 16'hffff, 16'h0000);
        acc(0, 10'h3ff, 16'h0000, 16'hffff);
        acc(0, 10'h001, 16'h0000, 16'h0000);
        chk("busy", busy_cnt_o, 16'(12 * CPA_ACC_LAT));
        // reset in mid-run clears the store and the busy count
        @(negedge clk_i);
        rst_b_i = 0;
        repeat (2) @(negedge clk_i);
        rst_b_i = 1;
        chk("idle", {15'h0000, port.en}, 16'h0000);
        acc(0, 10'h3ff, 16'h0000, CPA_MEM_RST);
        chk("busy", busy_cnt_o, 16'(CPA_ACC_LAT));
        end_of_test();
    end
endmodule
